//--- design/dcsb_pkg.sv
// Constants, frame encodings and shared helpers for the daisy-chain stack/broadcast link.
// Assumes one clock domain; CRC is a plain MSB-first CRC-16 with a zero residue.
package dcsb_pkg;

    // ****************************************
    // Frame encodings
    // ****************************************
    localparam logic [2:0] REQ_SGL_RD = 3'h0;
    localparam logic [2:0] REQ_SGL_WR = 3'h1;
    localparam logic [2:0] REQ_STK_RD = 3'h2;
    localparam logic [2:0] REQ_STK_WR = 3'h3;
    localparam logic [2:0] REQ_BC_RD = 3'h4;
    localparam logic [2:0] REQ_BC_WR = 3'h5;
    localparam logic [2:0] READ_SIZE = 3'h0;
    localparam logic CMD_FRAME_BIT = 1'b1;
    localparam logic RSP_FRAME_BIT = 1'b0;
    localparam logic [3:0] CMD_FIXED_BYTES = 4'h5;
    localparam logic [8:0] RSP_FIXED_BYTES = 9'h007;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_SEED = 16'hffff;

    // ****************************************
    // Host register map and status bits
    // ****************************************
    localparam logic [3:0] HREG_CMD = 4'h0;
    localparam logic [3:0] HREG_ADDR = 4'h1;
    localparam logic [3:0] HREG_DLO = 4'h2;
    localparam logic [3:0] HREG_DHI = 4'h3;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_MASK = 4'h5;
    localparam logic [3:0] HREG_RX = 4'h6;
    localparam int ST_TX_DONE = 0;
    localparam int ST_RX_OK = 1;
    localparam int ST_RX_CRC = 2;
    localparam int ST_W = 3;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic is_read(input logic [2:0] t);
        return (t == REQ_SGL_RD) || (t == REQ_STK_RD) || (t == REQ_BC_RD);
    endfunction

    // Whole command frame length, CRC included
    function automatic logic [3:0] cmd_len(input logic [7:0] init);
        logic [3:0] nd;
        nd = is_read(init[6:4]) ? 4'h1 : ({1'b0, init[2:0]} + 4'h1);
        return CMD_FIXED_BYTES + nd + {3'h0, init[6:5] == 2'h0};
    endfunction

    // Whole response frame length from its first byte
    function automatic logic [8:0] rsp_len(input logic [7:0] init);
        return {2'h0, init[6:0]} + RSP_FIXED_BYTES;
    endfunction

endpackage

//--- design/dcsb_link_if.sv
// Byte link between the host controller and the nearest chain device.
// Assumes both ends run on the same clock; one byte per valid cycle.
`timescale 1ns/1ps
interface dcsb_link_if;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic rsp_valid;
    logic [7:0] rsp_byte;

    modport host
    (
        output cmd_valid,
        output cmd_byte,
        input rsp_valid,
        input rsp_byte
    );

    modport dev
    (
        input cmd_valid,
        input cmd_byte,
        output rsp_valid,
        output rsp_byte
    );
endinterface

//--- design/dcsb_device_end.sv
// Chain device end: decodes stack/broadcast commands, writes registers, builds and
// relays read responses. Assumes the register file answers reads in the same cycle.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dcsb_device_end
    import dcsb_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    dcsb_link_if.dev lnk,
    input wire logic [7:0] dev_addr,
    input wire logic stack_member_flag,
    input wire logic highest_chain_device,
    input wire logic up_valid,
    input wire logic [7:0] up_byte,
    output logic fwd_valid,
    output logic [7:0] fwd_byte,
    output logic reg_wr_en,
    output logic [15:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic [15:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data,
    output logic cmd_crc_fault,
    output logic rsp_crc_fault
);

    typedef enum logic [1:0] {R_IDLE, R_WAIT, R_SEND} dcsb_rsp_state_t;

    // ****************************************
    // Command parser
    // ****************************************
    logic [3:0] c_cnt_reg;
    logic [3:0] c_len_reg;
    logic [7:0] c_init_reg;
    logic [15:0] c_addr_reg;
    logic [15:0] c_crc_reg;
    logic [7:0] c_data_reg [0:7];

    wire [2:0] c_type = c_init_reg[6:4];
    wire c_single = (c_init_reg[6:5] == 2'h0);
    wire [3:0] c_pos = c_cnt_reg - {3'h0, c_single};
    wire [2:0] c_didx = 3'(c_pos - 4'h3);
    wire c_first = (c_cnt_reg == 4'h0);
    wire [15:0] c_crc_next = crc_byte(c_first ? CRC_SEED : c_crc_reg, lnk.cmd_byte);
    wire c_end = lnk.cmd_valid && !c_first && (c_cnt_reg == c_len_reg - 4'h1);
    wire c_good = c_end && (c_crc_next == 16'h0000);
    wire c_bad = c_end && (c_crc_next != 16'h0000);
    wire c_is_stk = (c_type == REQ_STK_RD) || (c_type == REQ_STK_WR);
    wire c_is_bc = (c_type == REQ_BC_RD) || (c_type == REQ_BC_WR);
    wire c_hit = c_is_bc || (c_is_stk && stack_member_flag);
    wire exec_wr = c_good && c_hit && !is_read(c_type);
    wire exec_rd = c_good && c_hit && is_read(c_type);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            c_cnt_reg <= 4'h0;
            c_len_reg <= 4'h0;
            c_init_reg <= 8'h00;
            c_addr_reg <= 16'h0000;
            c_crc_reg <= 16'h0000;
            for (int i = 0; i < 8; i++)
            begin
                c_data_reg[i] <= 8'h00;
            end
        end
        else if (lnk.cmd_valid)
        begin
            c_crc_reg <= c_crc_next;
            if (c_first)
            begin
                c_init_reg <= lnk.cmd_byte;
                c_len_reg <= cmd_len(lnk.cmd_byte);
                c_cnt_reg <= 4'h1;
            end
            else
            begin
                c_cnt_reg <= c_end ? 4'h0 : c_cnt_reg + 4'h1;
                // Start address after the init byte and, in single frames, after the device-address byte
                if (c_pos == 4'h1)
                begin
                    c_addr_reg[15:8] <= lnk.cmd_byte;
                end
                if (c_pos == 4'h2)
                begin
                    c_addr_reg[7:0] <= lnk.cmd_byte;
                end
                if (c_pos >= 4'h3 && c_pos <= 4'ha)
                begin
                    c_data_reg[c_didx] <= lnk.cmd_byte;
                end
            end
        end
    end

    // ****************************************
    // Forward path toward the device above
    // ****************************************
    logic fwd_valid_reg;
    logic [7:0] fwd_byte_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fwd_valid_reg <= 1'b0;
            fwd_byte_reg <= 8'h00;
        end
        else
        begin
            fwd_valid_reg <= lnk.cmd_valid;
            fwd_byte_reg <= lnk.cmd_byte;
        end
    end

    assign fwd_valid = fwd_valid_reg;
    assign fwd_byte = fwd_byte_reg;

    // ****************************************
    // Register write engine
    // ****************************************
    logic [3:0] w_left_reg;
    logic [2:0] w_idx_reg;
    logic wr_en_reg;
    logic [15:0] wr_addr_reg;
    logic [7:0] wr_data_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            w_left_reg <= 4'h0;
            w_idx_reg <= 3'h0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= 8'h00;
        end
        else
        begin
            if (exec_wr)
            begin
                w_left_reg <= {1'b0, c_init_reg[2:0]} + 4'h1;
                w_idx_reg <= 3'h0;
            end
            else if (w_left_reg != 4'h0)
            begin
                w_left_reg <= w_left_reg - 4'h1;
                w_idx_reg <= w_idx_reg + 3'h1;
            end
            wr_en_reg <= (w_left_reg != 4'h0);
            wr_addr_reg <= c_addr_reg + {13'h0, w_idx_reg};
            wr_data_reg <= c_data_reg[w_idx_reg];
        end
    end

    assign reg_wr_en = wr_en_reg;
    assign reg_wr_addr = wr_addr_reg;
    assign reg_wr_data = wr_data_reg;

    // ****************************************
    // Upstream response tracker
    // ****************************************
    logic [8:0] u_cnt_reg;
    logic [8:0] u_len_reg;
    logic [7:0] u_addr_reg;
    logic [15:0] u_crc_reg;

    wire u_first = (u_cnt_reg == 9'h000);
    wire [15:0] u_crc_next = crc_byte(u_first ? CRC_SEED : u_crc_reg, up_byte);
    wire u_end = up_valid && !u_first && (u_cnt_reg == u_len_reg - 9'h001);
    wire u_good = u_end && (u_crc_next == 16'h0000);
    wire u_bad = u_end && (u_crc_next != 16'h0000);
    wire u_from_above = (u_addr_reg == dev_addr + 8'h01);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            u_cnt_reg <= 9'h000;
            u_len_reg <= 9'h000;
            u_addr_reg <= 8'h00;
            u_crc_reg <= 16'h0000;
        end
        else if (up_valid)
        begin
            u_crc_reg <= u_crc_next;
            u_cnt_reg <= u_end ? 9'h000 : u_cnt_reg + 9'h001;
            if (u_first)
            begin
                u_len_reg <= rsp_len(up_byte);
            end
            if (u_cnt_reg == 9'h001)
            begin
                u_addr_reg <= up_byte;
            end
        end
    end

    // ****************************************
    // Own response frame
    // ****************************************
    dcsb_rsp_state_t r_state_reg;
    logic [6:0] r_cnt_reg;
    logic [15:0] r_start_reg;
    logic [8:0] s_idx_reg;
    logic [15:0] s_crc_reg;
    logic [15:0] rd_addr_reg;
    logic rsp_valid_reg;
    logic [7:0] rsp_byte_reg;

    // Data occupies bytes 4 .. cnt+4, then two CRC bytes
    wire [8:0] s_crc_pos = {2'h0, r_cnt_reg} + 9'h005;
    wire s_data = (s_idx_reg >= 9'h004) && (s_idx_reg < s_crc_pos);
    wire s_last = (s_idx_reg == s_crc_pos + 9'h001);
    wire [7:0] s_byte =
        (s_idx_reg == 9'h000) ? {RSP_FRAME_BIT, r_cnt_reg} :
        (s_idx_reg == 9'h001) ? dev_addr :
        (s_idx_reg == 9'h002) ? r_start_reg[15:8] :
        (s_idx_reg == 9'h003) ? r_start_reg[7:0] :
        s_data ? reg_rd_data :
        (s_idx_reg == s_crc_pos) ? s_crc_reg[15:8] : s_crc_reg[7:0];
    wire s_go = (r_state_reg == R_SEND);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_state_reg <= R_IDLE;
            r_cnt_reg <= 7'h00;
            r_start_reg <= 16'h0000;
            s_idx_reg <= 9'h000;
            s_crc_reg <= 16'h0000;
            rd_addr_reg <= 16'h0000;
        end
        else
        begin
            unique case (r_state_reg)
                R_IDLE:
                begin
                    if (exec_rd)
                    begin
                        r_cnt_reg <= c_data_reg[0][6:0];
                        r_start_reg <= c_addr_reg;
                        rd_addr_reg <= c_addr_reg;
                        s_idx_reg <= 9'h000;
                        s_crc_reg <= CRC_SEED;
                        // Top device opens the chain
                        r_state_reg <= highest_chain_device ? R_SEND : R_WAIT;
                    end
                end
                R_WAIT:
                begin
                    if (u_bad)
                    begin
                        r_state_reg <= R_IDLE;
                    end
                    else if (u_good && u_from_above)
                    begin
                        r_state_reg <= R_SEND;
                    end
                end
                R_SEND:
                begin
                    s_idx_reg <= s_idx_reg + 9'h001;
                    if (s_idx_reg < s_crc_pos)
                    begin
                        s_crc_reg <= crc_byte(s_crc_reg, s_byte);
                    end
                    if (s_data)
                    begin
                        rd_addr_reg <= rd_addr_reg + 16'h0001;
                    end
                    if (s_last)
                    begin
                        r_state_reg <= R_IDLE;
                    end
                end
            endcase
        end
    end

    // Relay upstream frames; own frame follows the frame from the device above and wins over any upstream byte
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_byte_reg <= 8'h00;
        end
        else
        begin
            rsp_valid_reg <= s_go || up_valid;
            rsp_byte_reg <= s_go ? s_byte : up_byte;
        end
    end

    assign lnk.rsp_valid = rsp_valid_reg;
    assign lnk.rsp_byte = rsp_byte_reg;
    assign reg_rd_addr = rd_addr_reg;

    // ****************************************
    // Fault pulses
    // ****************************************
    logic cmd_fault_reg;
    logic rsp_fault_reg;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_fault_reg <= 1'b0;
            rsp_fault_reg <= 1'b0;
        end
        else
        begin
            cmd_fault_reg <= c_bad;
            rsp_fault_reg <= u_bad;
        end
    end

    assign cmd_crc_fault = cmd_fault_reg;
    assign rsp_crc_fault = rsp_fault_reg;

endmodule

//--- design/dcsb_host_end.sv
// Host controller end: builds stack/broadcast command frames from its registers and
// checks incoming response frames. Assumes software reaches it over the plain port.
`timescale 1ns/1ps
module dcsb_host_end
    import dcsb_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    dcsb_link_if.host lnk,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);

    typedef enum logic {H_IDLE, H_SEND} dcsb_tx_state_t;

    // ****************************************
    // Command registers and transmitter
    // ****************************************
    dcsb_tx_state_t t_state_reg;
    logic [2:0] h_type_reg;
    logic [2:0] h_size_reg;
    logic [15:0] h_addr_reg;
    logic [63:0] h_data_reg;
    logic [3:0] t_idx_reg;
    logic [15:0] t_crc_reg;
    logic cmd_valid_reg;
    logic [7:0] cmd_byte_reg;

    // Only stack and broadcast types are accepted
    wire type_ok = (wdata[6:5] == 2'h1) || (wdata[6:5] == 2'h2);
    wire go = wr && (addr == HREG_CMD) && (t_state_reg == H_IDLE) && type_ok;
    // Reads force a zero size
    wire [2:0] t_size = is_read(h_type_reg) ? READ_SIZE : h_size_reg;
    wire [7:0] t_init = {CMD_FRAME_BIT, h_type_reg, 1'b0, t_size};
    wire [3:0] t_len = cmd_len(t_init);
    wire [3:0] t_crc_pos = t_len - 4'h2;
    wire [2:0] t_k = 3'(t_idx_reg - 4'h3);
    // No device-address byte
    wire [7:0] t_byte =
        (t_idx_reg == 4'h0) ? t_init :
        (t_idx_reg == 4'h1) ? h_addr_reg[15:8] :
        (t_idx_reg == 4'h2) ? h_addr_reg[7:0] :
        (t_idx_reg < t_crc_pos) ? h_data_reg[{t_k, 3'h0} +: 8] :
        (t_idx_reg == t_crc_pos) ? t_crc_reg[15:8] : t_crc_reg[7:0];
    wire t_done = (t_state_reg == H_SEND) && (t_idx_reg == t_len - 4'h1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            t_state_reg <= H_IDLE;
            h_type_reg <= 3'h0;
            h_size_reg <= 3'h0;
            h_addr_reg <= 16'h0000;
            h_data_reg <= 64'h0;
            t_idx_reg <= 4'h0;
            t_crc_reg <= 16'h0000;
        end
        else
        begin
            if (wr && addr == HREG_ADDR)
            begin
                h_addr_reg <= wdata[15:0];
            end
            if (wr && addr == HREG_DLO)
            begin
                h_data_reg[31:0] <= wdata;
            end
            if (wr && addr == HREG_DHI)
            begin
                h_data_reg[63:32] <= wdata;
            end
            unique case (t_state_reg)
                H_IDLE:
                begin
                    if (go)
                    begin
                        h_type_reg <= wdata[6:4];
                        h_size_reg <= wdata[2:0];
                        t_idx_reg <= 4'h0;
                        t_crc_reg <= CRC_SEED;
                        t_state_reg <= H_SEND;
                    end
                end
                H_SEND:
                begin
                    t_idx_reg <= t_idx_reg + 4'h1;
                    if (t_idx_reg < t_crc_pos)
                    begin
                        t_crc_reg <= crc_byte(t_crc_reg, t_byte);
                    end
                    if (t_done)
                    begin
                        t_state_reg <= H_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_valid_reg <= 1'b0;
            cmd_byte_reg <= 8'h00;
        end
        else
        begin
            cmd_valid_reg <= (t_state_reg == H_SEND);
            cmd_byte_reg <= t_byte;
        end
    end

    assign lnk.cmd_valid = cmd_valid_reg;
    assign lnk.cmd_byte = cmd_byte_reg;

    // ****************************************
    // Response checker
    // ****************************************
    logic [8:0] r_cnt_reg;
    logic [8:0] r_len_reg;
    logic [15:0] r_crc_reg;
    logic [7:0] rx_addr_reg;
    logic [7:0] rx_byte_reg;
    logic [7:0] rx_frames_reg;

    wire r_first = (r_cnt_reg == 9'h000);
    wire [15:0] r_crc_next = crc_byte(r_first ? CRC_SEED : r_crc_reg, lnk.rsp_byte);
    wire r_end = lnk.rsp_valid && !r_first && (r_cnt_reg == r_len_reg - 9'h001);
    wire r_ok = r_end && (r_crc_next == 16'h0000);
    wire r_bad = r_end && (r_crc_next != 16'h0000);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_cnt_reg <= 9'h000;
            r_len_reg <= 9'h000;
            r_crc_reg <= 16'h0000;
            rx_addr_reg <= 8'h00;
            rx_byte_reg <= 8'h00;
            rx_frames_reg <= 8'h00;
        end
        else
        begin
            if (lnk.rsp_valid)
            begin
                r_crc_reg <= r_crc_next;
                r_cnt_reg <= r_end ? 9'h000 : r_cnt_reg + 9'h001;
                rx_byte_reg <= lnk.rsp_byte;
                if (r_first)
                begin
                    r_len_reg <= rsp_len(lnk.rsp_byte);
                end
                if (r_cnt_reg == 9'h001)
                begin
                    rx_addr_reg <= lnk.rsp_byte;
                end
            end
            if (go)
            begin
                rx_frames_reg <= 8'h00;
            end
            else if (r_ok)
            begin
                rx_frames_reg <= rx_frames_reg + 8'h01;
            end
        end
    end

    // ****************************************
    // Status, mask, interrupt, read port
    // ****************************************
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic irq_reg;
    logic [31:0] rdata_reg;

    wire [ST_W-1:0] events = {r_bad, r_ok, t_done};
    wire st_rd = rd && (addr == HREG_STATUS);
    // Set wins over the clear-on-read
    wire [ST_W-1:0] status_next = (st_rd ? {ST_W{1'b0}} : status_reg) | events;
    wire busy = (t_state_reg == H_SEND);
    wire [31:0] rd_mux =
        (addr == HREG_CMD) ? {23'h0, busy, 1'b0, h_type_reg, 1'b0, h_size_reg} :
        (addr == HREG_ADDR) ? {16'h0, h_addr_reg} :
        (addr == HREG_DLO) ? h_data_reg[31:0] :
        (addr == HREG_DHI) ? h_data_reg[63:32] :
        (addr == HREG_STATUS) ? {29'h0, status_reg} :
        (addr == HREG_MASK) ? {29'h0, mask_reg} :
        (addr == HREG_RX) ? {8'h0, rx_frames_reg, rx_addr_reg, rx_byte_reg} : 32'h0;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status_reg <= {ST_W{1'b0}};
            mask_reg <= {ST_W{1'b0}};
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            status_reg <= status_next;
            if (wr && addr == HREG_MASK)
            begin
                mask_reg <= wdata[ST_W-1:0];
            end
            irq_reg <= |(status_reg & mask_reg);
            rdata_reg <= rd ? rd_mux : 32'h0;
        end
    end

    assign irq = irq_reg;
    assign rdata = rdata_reg;

endmodule

//--- bench/dcsb_link_asserts.sv
// Checker for the host-to-device link: command framing and response framing.
// Assumes one clock, active-high reset and a single device flagged as highest.
`timescale 1ns/1ps
module dcsb_link_asserts
    import dcsb_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte
);
    // ****
    // Frame trackers
    // ****
    logic [3:0] cnt_reg;
    logic [8:0] rc_reg;
    logic [7:0] init_reg;
    logic [7:0] dat_reg;
    wire logic [3:0] len = init_reg[4] ? 4'h6 + {1'b0, init_reg[2:0]} : 4'h6;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
            rc_reg <= 9'h000;
            init_reg <= 8'h00;
            dat_reg <= 8'h00;
        end
        else
        begin
            cnt_reg <= cmd_valid ? cnt_reg + 4'h1 : 4'h0;
            rc_reg <= rsp_valid ? rc_reg + 9'h001 : 9'h000;
            init_reg <= (cmd_valid && cnt_reg == 4'h0) ? cmd_byte : init_reg;
            dat_reg <= (cmd_valid && cnt_reg == 4'h3) ? cmd_byte : dat_reg;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd_frame;
        cmd_valid [*6] ##1 !cmd_valid;
    endsequence
    property p_stk_rd;
        $rose(cmd_valid) && cmd_byte[6:4] == REQ_STK_RD |-> cmd_byte == 8'ha0; endproperty
    a_stk_rd: assert property (p_stk_rd) else $error("stack read init byte wrong");
    property p_stk_wr;
        $rose(cmd_valid) && cmd_byte[6:4] == REQ_STK_WR |-> cmd_byte[7:3] == 5'h16; endproperty
    a_stk_wr: assert property (p_stk_wr) else $error("stack write init byte wrong");
    property p_bc_rd;
        $rose(cmd_valid) && cmd_byte[6:4] == REQ_BC_RD |-> cmd_byte[2:0] == READ_SIZE; endproperty
    a_bc_rd: assert property (p_bc_rd) else $error("read size field not zero");
    property p_rd_len;
        $rose(cmd_valid) && !cmd_byte[4] |-> s_rd_frame; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read frame length wrong");
    property p_wr_len;
        $fell(cmd_valid) |-> cnt_reg == len; endproperty
    a_wr_len: assert property (p_wr_len) else $error("command frame length wrong");
    property p_rsp_go;
        $fell(cmd_valid) && init_reg[6:4] == REQ_BC_RD |-> ##[1:2] $rose(rsp_valid); endproperty
    a_rsp_go: assert property (p_rsp_go) else $error("top device did not answer");
    property p_rsp_hdr;
        $rose(rsp_valid) |-> rsp_byte == {1'b0, dat_reg[6:0]}; endproperty
    a_rsp_hdr: assert property (p_rsp_hdr) else $error("response count byte wrong");
    property p_rsp_len;
        $fell(rsp_valid) |-> rc_reg == {2'h0, dat_reg[6:0]} + 9'h007; endproperty
    a_rsp_len: assert property (p_rsp_len) else $error("response length wrong");
endmodule

//--- bench/tb.sv
// Bench: host end and one highest device joined by the link, random stack/broadcast traffic.
// Assumes the device register file answers reads in the same cycle.
`timescale 1ns/1ps
module tb
    import dcsb_pkg::*;
;
    logic clk = 0, sys_rst = 1, wr = 0, rd = 0, flag = 0, wen, irq;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic [7:0] dad = 0, wd, rdd;
    logic [15:0] wa, ra, sa;
    logic [23:0] q[$];
    logic [63:0] d;
    logic [2:0] t, sz;
    int n_errors = 0, comparisons = 0, cyc = 0;
    logic fv, cf, rf;
    int nfwd = 0, efwd = 0, nflt = 0;
    dcsb_link_if lnk();
    dcsb_host_end u_dcsb_host_end(.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    dcsb_device_end u_dcsb_device_end(.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .dev_addr(dad),
        .stack_member_flag(flag), .highest_chain_device(1'b1), .up_valid(1'b0),
        .up_byte(8'h00), .fwd_valid(fv), .fwd_byte(), .reg_wr_en(wen), .reg_wr_addr(wa),
        .reg_wr_data(wd), .reg_rd_addr(ra), .reg_rd_data(rdd), .cmd_crc_fault(cf),
        .rsp_crc_fault(rf));
    dcsb_link_asserts u_dcsb_link_asserts(.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(lnk.cmd_valid), .cmd_byte(lnk.cmd_byte), .rsp_valid(lnk.rsp_valid),
        .rsp_byte(lnk.rsp_byte));
    assign rdd = ra[7:0] ^ ra[15:8];
    initial forever #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (wen)
            q.push_back({wa, wd});
        if (fv)
            nfwd++;
        if (cf || rf)
            nflt++;
        if (cyc == 20000)
        begin
            n_errors++;
            results();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (e !== s)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task bw(input logic [3:0] a, input logic [31:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task br(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
    endtask
    task results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(38017));
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        for (int i = 0; i < 24; i++)
        begin
            t = 3'(2 + i % 4);
            sz = i < 8 ? 3'(i) : 3'($urandom);
            d = {$urandom, $urandom};
            d[7] = d[7] & t[0];
            sa = 16'($urandom);
            flag <= 1'($urandom);
            dad <= 8'($urandom);
            q.delete();
            bw(HREG_MASK, {31'h0, i < 20});
            bw(HREG_ADDR, {16'h0, sa});
            bw(HREG_DLO, d[31:0]);
            bw(HREG_DHI, d[63:32]);
            bw(HREG_CMD, {25'h0, t, 1'b0, sz});
            efwd += t[0] ? 32'(sz) + 6 : 6;
            repeat (200) @(posedge clk);
            if (t[0])
            begin
                chk("writes", (t[2] || flag) ? 32'(sz) + 1 : 0, q.size());
                foreach (q[k])
                    chk("write", {sa + 16'(k), d[8*k+:8]}, q[k]);
            end
            else
            begin
                br(HREG_RX);
                chk("frames", t[2] || flag, v[23:16]);
                if (t[2] || flag)
                    chk("rsp addr", dad, v[15:8]);
            end
            chk("irq", i < 20, irq);
            br(HREG_STATUS);
            chk("tx done", 1, v[0]);
            repeat (2) @(posedge clk);
            chk("irq clear", 0, irq);
        end
        br(4'hf);
        chk("unmapped", 0, v);
        chk("fwd bytes", efwd, nfwd);
        chk("crc faults", 0, nflt);
        results();
    end
endmodule
